//--- rtl/bypass_ldo_fault_control.sv
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Bypass mode: high-side switch is plain on/off, low-side stays off.
// - Bypass rail turns on after sequencing delay, then ramps for soft-start.
// - Bypass current-limit flag follows overcurrent detector and drives interrupt.
// - Current-limit flag stays set until host reads status.
// - Current fault mask keeps current-limit events off the interrupt.
// - Unmasked current shutdown enters fault state and turns every regulator off.
// - Fault state waits 100 ms then restarts through programmed sequence.
// - Undervoltage mask suppresses shutdown fault and latched bit; only live flag shows it.
// - Overvoltage flag never asserts for the bypass output.
// - Linear regulators ramp 275 us on every enable and restart.
// - Each linear regulator has one voltage code register only.
// - Target is 0.8V+code*12.5mV, or 0.6V+code*9.375mV with range set.
// - Range select comes from factory image; host writes cannot change it.
// - Host write to a linear regulator's on bit enables or disables it.
// - Disabled linear regulator connects its discharge path.
// - Power-OK bit reads zero while output is under threshold.
// - Enabled regulator fault interrupt drives interrupt low on power-OK loss.
// - Interrupt stays low until off or regulated, and power-OK read.
module bypass_ldo_fault_control
  import bypass_ldo_pkg::*;
#(
  parameter int unsigned RESTART_COUNT = RESTART_CYCLES,
  parameter int unsigned SS_COUNT      = LDO_SS_CYCLES,
  parameter logic [7:0]  LDO1_DEFAULT  = 8'h40,
  parameter logic [7:0]  LDO2_DEFAULT  = 8'h50
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Factory image
  input  wire logic       factory_config_image,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Analog detectors
  input  wire logic       bypass_overcurrent,
  input  wire logic       bypass_current_shutdown,
  input  wire logic       ldo1_below_pok,
  input  wire logic       ldo2_below_pok,
  // Power controls
  output logic            high_side_on,
  output logic            low_side_on,
  output logic            bypass_ramping,
  output logic            ldo1_enable,
  output logic            ldo2_enable,
  output logic            ldo1_ramping,
  output logic            ldo2_ramping,
  output logic            ldo1_discharge,
  output logic            ldo2_discharge,
  output logic            fault_interrupt_n
);

  localparam int unsigned RW = $clog2(RESTART_COUNT + 1);
  localparam int unsigned SW = $clog2(SS_COUNT + 1) + 8;

  initial begin
    if (RESTART_COUNT < 1 || SS_COUNT < 1) begin
      $error("Counts must be at least one");
    end
  end

  // Input synchronisers
  logic [1:0] oc_s;
  logic [1:0] sd_s;
  logic [1:0] b1_s;
  logic [1:0] b2_s;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      oc_s <= 2'b00;
      sd_s <= 2'b00;
      b1_s <= 2'b00;
      b2_s <= 2'b00;
    end else begin
      oc_s <= {oc_s[0], bypass_overcurrent};
      sd_s <= {sd_s[0], bypass_current_shutdown};
      b1_s <= {b1_s[0], ldo1_below_pok};
      b2_s <= {b2_s[0], ldo2_below_pok};
    end
  end
  logic oc;
  logic sd;
  logic low1;
  logic low2;
  assign oc   = oc_s[1];
  assign sd   = sd_s[1];
  assign low1 = b1_s[1];
  assign low2 = b2_s[1];

  // Registers
  logic       bypass_mode;
  logic       switch_on;
  logic       ldo1_on;
  logic       ldo2_on;
  logic       range_sel;
  logic       cfg_taken;
  logic       current_fault_mask;
  logic       undervoltage_fault_mask;
  logic [1:0] fault_irq_enable;
  logic [7:0] linreg1_voltage_code, linreg2_voltage_code;
  logic [7:0] seq_delay;
  logic       wr_ctrl;
  logic       wr_mask;
  logic       rd_status;
  assign wr_ctrl   = reg_wr && reg_addr == REG_CTRL;
  assign wr_mask   = reg_wr && reg_addr == REG_MASK;
  assign rd_status = reg_rd && reg_addr == REG_STATUS;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bypass_mode <= CTRL_RESET[CTRL_BYPASS];
      switch_on   <= CTRL_RESET[CTRL_SWITCH];
      ldo1_on     <= CTRL_RESET[CTRL_LDO1_ON];
      ldo2_on     <= CTRL_RESET[CTRL_LDO2_ON];
    end else if (wr_ctrl) begin
      bypass_mode <= reg_wdata[CTRL_BYPASS];
      switch_on   <= reg_wdata[CTRL_SWITCH];
      ldo1_on     <= reg_wdata[CTRL_LDO1_ON];
      ldo2_on     <= reg_wdata[CTRL_LDO2_ON];
    end
  end

  // Range captured from factory image after reset release
  always_ff @(posedge core_clk) begin
    if (rst) begin
      range_sel <= 1'b0;
      cfg_taken <= 1'b0;
    end else if (!cfg_taken) begin
      range_sel <= factory_config_image;
      cfg_taken <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      current_fault_mask      <= MASK_RESET[MSK_CURRENT_LIMIT_FLAG];
      undervoltage_fault_mask <= MASK_RESET[MSK_UV];
      fault_irq_enable        <= MASK_RESET[MSK_IRQ_EN2:MSK_IRQ_EN1];
    end else if (wr_mask) begin
      current_fault_mask      <= reg_wdata[MSK_CURRENT_LIMIT_FLAG];
      undervoltage_fault_mask <= reg_wdata[MSK_UV];
      fault_irq_enable        <= reg_wdata[MSK_IRQ_EN2:MSK_IRQ_EN1];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      linreg1_voltage_code <= LDO1_DEFAULT;
      linreg2_voltage_code <= LDO2_DEFAULT;
      seq_delay            <= SEQ_RESET;
    end else if (reg_wr) begin
      if (reg_addr == REG_LDO1_SET) linreg1_voltage_code <= reg_wdata;
      if (reg_addr == REG_LDO2_SET) linreg2_voltage_code <= reg_wdata;
      if (reg_addr == REG_SEQ)      seq_delay <= reg_wdata;
    end
  end

  // Fault flags
  logic current_limit_flag;
  logic undervoltage_latched;
  logic voltage_fault_state;
  logic undervoltage_flag;
  logic overvoltage_flag;
  assign undervoltage_flag = bypass_mode && sd;
  assign overvoltage_flag  = 1'b0;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      current_limit_flag <= 1'b0;
    end else if (bypass_mode && oc) begin
      current_limit_flag <= 1'b1;
    end else if (rd_status) begin
      current_limit_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      undervoltage_latched <= 1'b0;
    end else if (undervoltage_flag && !undervoltage_fault_mask) begin
      undervoltage_latched <= 1'b1;
    end else if (rd_status && !undervoltage_flag) begin
      undervoltage_latched <= 1'b0;
    end
  end

  // Fault state and restart timer
  logic [RW-1:0] restart_cnt;
  logic          restart_pulse;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      voltage_fault_state <= 1'b0;
      restart_cnt         <= '0;
      restart_pulse       <= 1'b0;
    end else begin
      restart_pulse <= 1'b0;
      if (undervoltage_flag && !undervoltage_fault_mask) begin
        voltage_fault_state <= 1'b1;
        restart_cnt         <= '0;
      end else if (voltage_fault_state) begin
        if (restart_cnt == RW'(RESTART_COUNT - 1)) begin
          voltage_fault_state <= 1'b0;
          restart_pulse       <= 1'b1;
        end else begin
          restart_cnt <= restart_cnt + 1'b1;
        end
      end
    end
  end

  // Bypass switch sequencing
  bypass_state_t state;
  logic [SW-1:0] bcnt;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= ST_OFF;
      bcnt  <= '0;
    end else if (voltage_fault_state || !bypass_mode || !switch_on) begin
      state <= ST_OFF;
      bcnt  <= '0;
    end else begin
      unique case (state)
        ST_OFF: begin
          state <= ST_DELAY;
          bcnt  <= '0;
        end
        ST_DELAY: begin
          if (bcnt >= SW'(seq_delay) * SW'(SS_COUNT)) begin
            state <= ST_RAMP;
            bcnt  <= '0;
          end else begin
            bcnt <= bcnt + 1'b1;
          end
        end
        ST_RAMP: begin
          if (bcnt == SW'(SS_COUNT - 1)) begin
            state <= ST_ON;
          end else begin
            bcnt <= bcnt + 1'b1;
          end
        end
        ST_ON: state <= ST_ON;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      high_side_on   <= 1'b0;
      low_side_on    <= 1'b0;
      bypass_ramping <= 1'b0;
    end else begin
      high_side_on   <= state == ST_RAMP || state == ST_ON;
      low_side_on    <= 1'b0;
      bypass_ramping <= state == ST_RAMP;
    end
  end

  // Linear regulator enables, soft-start and discharge
  logic [1:0] lon;
  logic [1:0] lon_d;
  logic [SW-1:0] scnt [2];
  assign lon[0] = ldo1_on && !voltage_fault_state;
  assign lon[1] = ldo2_on && !voltage_fault_state;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lon_d   <= 2'b00;
      scnt[0] <= '0;
      scnt[1] <= '0;
    end else begin
      lon_d <= lon;
      for (int i = 0; i < 2; i++) begin
        if (lon[i] && !lon_d[i]) begin
          scnt[i] <= SW'(SS_COUNT);
        end else if (!lon[i]) begin
          scnt[i] <= '0;
        end else if (scnt[i] != '0) begin
          scnt[i] <= scnt[i] - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ldo1_enable    <= 1'b0;
      ldo2_enable    <= 1'b0;
      ldo1_ramping   <= 1'b0;
      ldo2_ramping   <= 1'b0;
      ldo1_discharge <= 1'b1;
      ldo2_discharge <= 1'b1;
    end else begin
      ldo1_enable    <= lon[0];
      ldo2_enable    <= lon[1];
      ldo1_ramping   <= lon[0] && (scnt[0] != '0 || !lon_d[0]);
      ldo2_ramping   <= lon[1] && (scnt[1] != '0 || !lon_d[1]);
      ldo1_discharge <= !lon[0];
      ldo2_discharge <= !lon[1];
    end
  end

  // Power-OK and interrupt hold
  logic [1:0] power_ok_flag;
  logic [1:0] pok_pend;
  assign power_ok_flag[0] = lon[0] && !low1;
  assign power_ok_flag[1] = lon[1] && !low2;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pok_pend <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (fault_irq_enable[i] && lon[i] && !power_ok_flag[i]) begin
          pok_pend[i] <= 1'b1;
        end else if (rd_status) begin
          pok_pend[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fault_interrupt_n <= 1'b1;
    end else begin
      fault_interrupt_n <= !((current_limit_flag && !current_fault_mask)
                             || undervoltage_latched || (|pok_pend));
    end
  end

  // Target voltage in microvolts
  function automatic logic [31:0] vtarget(input logic [7:0] code, input logic rng);
    logic [31:0] step;
    step = rng ? STEP1_NV : STEP0_NV;
    return (rng ? VREF1_UV : VREF0_UV) + (32'(code) * step) / NV_PER_UV;
  endfunction
  logic [31:0] vt1;
  logic [31:0] vt2;
  assign vt1 = vtarget(linreg1_voltage_code, range_sel);
  assign vt2 = vtarget(linreg2_voltage_code, range_sel);

  // Read data
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL:     reg_rdata <= {3'b000, range_sel, ldo2_on, ldo1_on, switch_on, bypass_mode};
        REG_STATUS:   reg_rdata <= {1'b0, voltage_fault_state, power_ok_flag, overvoltage_flag,
                                    undervoltage_latched, undervoltage_flag, current_limit_flag};
        REG_MASK:     reg_rdata <= {4'h0, fault_irq_enable, undervoltage_fault_mask,
                                    current_fault_mask};
        REG_LDO1_SET: reg_rdata <= linreg1_voltage_code;
        REG_LDO2_SET: reg_rdata <= linreg2_voltage_code;
        REG_SEQ:      reg_rdata <= seq_delay;
        REG_VTARGET1: reg_rdata <= vt1[19:12];
        REG_VTARGET2: reg_rdata <= vt2[19:12];
        default:      reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : bypass_ldo_fault_control

`default_nettype wire

//--- include/bypass_ldo_pkg.sv
package bypass_ldo_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS      = 100;
  localparam int unsigned RESTART_DELAY_MS   = 100;
  localparam int unsigned RESTART_CYCLES     = (RESTART_DELAY_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned LDO_SOFTSTART_US   = 275;
  localparam int unsigned LDO_SS_CYCLES      =
    (LDO_SOFTSTART_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte addresses (byte address = 4 * index)
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_MASK     = 8'h08;
  localparam logic [7:0] REG_LDO1_SET = 8'h0C;
  localparam logic [7:0] REG_LDO2_SET = 8'h10;
  localparam logic [7:0] REG_SEQ      = 8'h14;
  localparam logic [7:0] REG_VTARGET1 = 8'h18;
  localparam logic [7:0] REG_VTARGET2 = 8'h1C;

  // CTRL fields
  localparam int unsigned CTRL_BYPASS   = 0;
  localparam int unsigned CTRL_SWITCH   = 1;
  localparam int unsigned CTRL_LDO1_ON  = 2;
  localparam int unsigned CTRL_LDO2_ON  = 3;
  localparam int unsigned CTRL_RANGE    = 4;

  // STATUS fields
  localparam int unsigned ST_CURRENT_LIMIT_FLAG       = 0;
  localparam int unsigned ST_UV         = 1;
  localparam int unsigned ST_UV_LATCH   = 2;
  localparam int unsigned ST_OV         = 3;
  localparam int unsigned ST_POK1       = 4;
  localparam int unsigned ST_POK2       = 5;
  localparam int unsigned ST_FAULT      = 6;

  // MASK fields
  localparam int unsigned MSK_CURRENT_LIMIT_FLAG      = 0;
  localparam int unsigned MSK_UV        = 1;
  localparam int unsigned MSK_IRQ_EN1   = 2;
  localparam int unsigned MSK_IRQ_EN2   = 3;

  // Voltage arithmetic: references in microvolts, steps in nanovolts
  localparam logic [31:0] VREF0_UV      = 32'h000C_3500;
  localparam logic [31:0] VREF1_UV      = 32'h0009_27C0;
  localparam logic [31:0] STEP0_NV      = 32'h00BE_BC20;
  localparam logic [31:0] STEP1_NV      = 32'h008F_0D18;
  localparam logic [31:0] NV_PER_UV     = 32'h0000_03E8;

  // Reset values
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  MASK_RESET    = 8'h03;
  localparam logic [7:0]  SEQ_RESET     = 8'h10;

  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_DELAY = 2'b01,
    ST_RAMP  = 2'b10,
    ST_ON    = 2'b11
  } bypass_state_t;

endpackage : bypass_ldo_pkg

//--- tb/ldo_plant.sv
`timescale 1ns/100ps
`default_nettype none
module ldo_plant (
  // Controls from the block
  input  wire logic enable,
  input  wire logic ramping,
  // Load fault from the bench
  input  wire logic droop,
  // Detector back to the block
  output logic      below_pok
);
  // Output low while off, ramping or overloaded
  assign below_pok = !enable || ramping || droop;
endmodule : ldo_plant
`default_nettype wire

//--- tb/bypass_ldo_fault_control_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module bypass_ldo_checker
  import bypass_ldo_pkg::*;
(
  // Clock, reset, register port
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  // Detectors
  input wire logic       bypass_overcurrent,
  input wire logic       bypass_current_shutdown,
  input wire logic       ldo1_below_pok,
  // Controls
  input wire logic       high_side_on,
  input wire logic       low_side_on,
  input wire logic       bypass_ramping,
  input wire logic       ldo1_enable,
  input wire logic       ldo2_enable,
  input wire logic       ldo1_ramping,
  input wire logic       ldo1_discharge,
  input wire logic       fault_interrupt_n
);
  logic [7:0] mask_sh;
  logic [2:0] since_rd;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Shadow of the mask register
  always_ff @(posedge core_clk) begin
    if (rst) mask_sh <= MASK_RESET;
    else if (reg_wr && reg_addr == REG_MASK) mask_sh <= reg_wdata;
  end
  // Cycles since the last status read
  always_ff @(posedge core_clk) begin
    if (rst || (reg_rd && reg_addr == REG_STATUS)) since_rd <= 3'h0;
    else if (since_rd != 3'h7) since_rd <= since_rd + 3'h1;
  end
  a_low_side_off: assert property (!low_side_on)
    else $error("low side switch driven");
  a_bypass_ramp: assert property ($rose(bypass_ramping) |-> bypass_ramping[*5])
    else $error("bypass ramp too short");
  a_current_limit_flag_irq: assert property ($rose(bypass_overcurrent) && high_side_on
    && !mask_sh[MSK_CURRENT_LIMIT_FLAG] |-> ##[1:6] !fault_interrupt_n) else $error("no current irq");
  a_shutdown_off: assert property ($rose(bypass_current_shutdown) && high_side_on
    && !mask_sh[MSK_UV] |-> ##[1:6] (!high_side_on && !ldo1_enable && !ldo2_enable))
    else $error("shutdown left a supply on");
  a_restart_wait: assert property ($rose(bypass_current_shutdown) && high_side_on
    && !mask_sh[MSK_UV] |-> ##40 !high_side_on) else $error("restart too early");
  a_ldo_off_write: assert property (reg_wr && reg_addr == REG_CTRL
    && !reg_wdata[CTRL_LDO1_ON] |-> ##[1:3] !ldo1_enable) else $error("ldo stays on");
  a_ldo_soft_ramp: assert property ($rose(ldo1_enable) |-> ##[0:1] ldo1_ramping[*5])
    else $error("ldo ramp missing");
  a_discharge_off: assert property ($stable(ldo1_enable) |-> ldo1_discharge != ldo1_enable)
    else $error("discharge wrong");
  a_pok_irq: assert property ($rose(ldo1_below_pok) && ldo1_enable && !ldo1_ramping
    && mask_sh[MSK_IRQ_EN1] |-> ##[1:6] !fault_interrupt_n) else $error("no pok irq");
  a_irq_release: assert property ($rose(fault_interrupt_n) |-> since_rd < 3'h4)
    else $error("irq released without read");
endmodule : bypass_ldo_checker
bind bypass_ldo_fault_control bypass_ldo_checker i_bypass_ldo_checker (.core_clk(core_clk),
  .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .bypass_overcurrent(bypass_overcurrent), .bypass_current_shutdown(bypass_current_shutdown),
  .ldo1_below_pok(ldo1_below_pok), .high_side_on(high_side_on), .low_side_on(low_side_on),
  .bypass_ramping(bypass_ramping), .ldo1_enable(ldo1_enable), .ldo2_enable(ldo2_enable),
  .ldo1_ramping(ldo1_ramping), .ldo1_discharge(ldo1_discharge),
  .fault_interrupt_n(fault_interrupt_n));
`default_nettype wire

//--- tb/bypass_ldo_fault_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module bypass_ldo_fault_control_tb
  import bypass_ldo_pkg::*;
;
  logic core_clk, rst, strap, wr, rd, oc, sd, dr1, dr2;
  logic [7:0] addr, wdata, rdata, s;
  wire logic hs, ls, bramp, en1, en2, rmp1, rmp2, dis1, dis2, irq_n, bp1, bp2;
  int failures = 0, total_checks = 0, n, v;
  bypass_ldo_fault_control #(.RESTART_COUNT(50), .SS_COUNT(5)) i_bypass_ldo_fault_control (
    .core_clk(core_clk), .rst(rst), .factory_config_image(strap), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .bypass_overcurrent(oc), .bypass_current_shutdown(sd), .ldo1_below_pok(bp1),
    .ldo2_below_pok(bp2), .high_side_on(hs), .low_side_on(ls), .bypass_ramping(bramp),
    .ldo1_enable(en1), .ldo2_enable(en2), .ldo1_ramping(rmp1), .ldo2_ramping(rmp2),
    .ldo1_discharge(dis1), .ldo2_discharge(dis2), .fault_interrupt_n(irq_n));
  ldo_plant i_ldo_plant1 (.enable(en1), .ramping(rmp1), .droop(dr1), .below_pok(bp1));
  ldo_plant i_ldo_plant2 (.enable(en2), .ramping(rmp2), .droop(dr2), .below_pok(bp2));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wreg
  task rreg(input logic [7:0] a);
    @(posedge core_clk);
    addr <= a; rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    @(negedge core_clk);
    s = rdata;
  endtask : rreg
  task cyc(input int c);
    repeat (c) @(posedge core_clk);
  endtask : cyc
  initial begin
    #2000000;
    failures++;
    $display("MISMATCH t=%0t watchdog", $time);
    stop_test;
  end
  initial begin
    {rst, strap, wr, rd, oc, sd, dr1, dr2, addr, wdata} = '0;
    rst = 1'b1;
    for (int r = 0; r < 2; r++) begin
      @(posedge core_clk);
      rst <= 1'b1; strap <= r[0];
      cyc(5);
      rst <= 1'b0;
      rreg(REG_CTRL); chk(s, {3'h0, r[0], 4'h0}, "ctrl");
      rreg(REG_MASK); chk(s, MASK_RESET, "mask");
      rreg(REG_SEQ); chk(s, SEQ_RESET, "seq");
      rreg(8'h20); chk(s, 8'h00, "unmapped");
      wreg(REG_CTRL, 8'h10); rreg(REG_CTRL); chk(s, {3'h0, r[0], 4'h0}, "range");
      wreg(REG_LDO1_SET, 8'h40);
      rreg(REG_LDO1_SET); chk(s, 8'h40, "code");
      v = r ? 600000 + 64 * 9375 : 800000 + 64 * 12500;
      rreg(REG_VTARGET1); chk(s, v[19:12], "target");
    end
    $display("test decode done");
    wreg(REG_MASK, 8'h07); wreg(REG_CTRL, 8'h0C); cyc(12);
    chk({en1, dis1}, 8'h02, "ldo on");
    chk({en2, dis2}, 8'h02, "ldo2 on");
    rreg(REG_STATUS); chk(s[ST_POK1], 8'h01, "pok up");
    chk(s[ST_POK2], 8'h01, "pok2 up");
    dr1 <= 1'b1; cyc(8); chk(irq_n, 8'h00, "pok irq");
    rreg(REG_STATUS); chk(s[ST_POK1], 8'h00, "pok low");
    dr1 <= 1'b0; cyc(6); chk(irq_n, 8'h00, "irq held");
    rreg(REG_STATUS); cyc(4); chk(irq_n, 8'h01, "irq free");
    wreg(REG_CTRL, 8'h00); cyc(4); chk({en1, dis1}, 8'h01, "ldo off");
    chk({en2, dis2}, 8'h01, "ldo2 off");
    $display("test ldo done");
    wreg(REG_SEQ, 8'h01); wreg(REG_CTRL, 8'h03);
    n = 0;
    v = 0;
    while (!hs && n < 200) begin
      @(posedge core_clk);
      n++;
      if (bramp) v = 1;
    end
    chk({hs, ls}, 8'h02, "switch on");
    chk(v[7:0], 8'h01, "ramped");
    oc <= 1'b1; cyc(6); oc <= 1'b0; cyc(6); chk(irq_n, 8'h01, "masked");
    rreg(REG_STATUS); chk(s[ST_CURRENT_LIMIT_FLAG], 8'h01, "current_limit_flag set");
    rreg(REG_STATUS); chk(s[ST_CURRENT_LIMIT_FLAG], 8'h00, "current_limit_flag clr");
    wreg(REG_MASK, 8'h00); oc <= 1'b1; cyc(6); chk(irq_n, 8'h00, "current_limit_flag irq");
    rreg(REG_STATUS); oc <= 1'b0; cyc(6);
    rreg(REG_STATUS); chk(s[ST_CURRENT_LIMIT_FLAG], 8'h01, "current_limit_flag held");
    cyc(4); chk(irq_n, 8'h01, "irq free");
    $display("test limit done");
    sd <= 1'b1; cyc(6); chk({hs, en1, en2}, 8'h00, "all off");
    sd <= 1'b0;
    rreg(REG_STATUS); chk(s & 8'h4C, 8'h44, "fault bits");
    n = 0;
    while (!hs && n < 200) begin
      rreg(REG_STATUS);
      n++;
    end
    chk(hs, 8'h01, "restart");
    chk(n > 15, 8'h01, "restart delay");
    wreg(REG_MASK, 8'h02); sd <= 1'b1; cyc(8); chk(hs, 8'h01, "uv masked");
    sd <= 1'b0;
    $display("test fault done");
    stop_test;
  end
endmodule : bypass_ldo_fault_control_tb
`default_nettype wire
